// [swcf_pkg.sv]
// package for the selective-wake frame filter configuration block
package swcf_pkg;

  // register addresses (7-bit configuration port address space)
  localparam logic [6:0] ADDR_WAKE_SAMPLE_POINT = 7'h22;
  localparam logic [6:0] ADDR_WAKE_ID_BYTE3 = 7'h23;
  localparam logic [6:0] ADDR_WAKE_ID_BYTE2 = 7'h24;
  localparam logic [6:0] ADDR_WAKE_ID_BYTE1 = 7'h25;
  localparam logic [6:0] ADDR_WAKE_ID_BYTE0_FORMAT = 7'h26;
  localparam logic [6:0] ADDR_WAKE_MASK_BYTE3 = 7'h27;
  localparam logic [6:0] ADDR_WAKE_MASK_BYTE2 = 7'h28;
  localparam logic [6:0] ADDR_WAKE_MASK_BYTE1 = 7'h29;
  localparam logic [6:0] ADDR_WAKE_MASK_BYTE0 = 7'h2a;
  localparam logic [6:0] ADDR_WAKE_LENGTH_CODE = 7'h2b;

  // writable bits per register
  localparam logic [7:0] WMASK_SAMPLE_POINT = 8'h3f;
  localparam logic [7:0] WMASK_FULL = 8'hff;
  localparam logic [7:0] WMASK_ID_BYTE0 = 8'h7f;
  localparam logic [7:0] WMASK_MASK_BYTE0 = 8'h7c;
  localparam logic [7:0] WMASK_LENGTH_CODE = 8'h0f;

  // field positions in the lowest identifier register, plus the standard identifier offset in the 29-bit identifier
  localparam int POS_LOW_BITS = 2;
  localparam int POS_RTR = 1;
  localparam int POS_IDE = 0;
  localparam int POS_STD_ID = 18;

  // values after power-on or soft reset, and the payload byte limit
  localparam logic [5:0] RST_SAMPLE_POINT = 6'h33;
  localparam logic [7:0] RST_ZERO_BYTE = 8'h00;
  localparam logic [3:0] RST_LENGTH_CODE = 4'h0;
  localparam logic [3:0] LEN_MAX_BYTES = 4'h8;

endpackage

// [swcf_filter_config.sv]
// selective-wake frame filter configuration registers and frame matcher
`timescale 1ns/1ps
`default_nettype none

module swcf_filter_config
  import swcf_pkg::*;
(
  // clock and resets
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic soft_reset_in,
  input wire logic restart_in,
  // configuration port
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [6:0] cfg_addr_in,
  input wire logic [7:0] cfg_wdata_in,
  output logic [7:0] cfg_rdata_out,
  output logic cfg_hit_out,
  // configuration valid flag handling
  input wire logic config_valid_set_in,
  input wire logic config_valid_clear_in,
  output logic config_valid_flag_out,
  // received wake-up frame from the recovery logic
  input wire logic wake_up_frame_strobe_in,
  input wire logic [28:0] wake_up_frame_id_in,
  input wire logic wake_up_frame_ide_in,
  input wire logic wake_up_frame_rtr_in,
  input wire logic [3:0] wake_up_frame_dlc_in,
  // decoded configuration
  output logic [5:0] sample_point_fraction_out,
  output logic [28:0] ref_ident_out,
  output logic [28:0] compare_enable_out,
  output logic ref_rtr_out,
  output logic ref_ide_out,
  output logic [3:0] ref_length_code_out,
  output logic [3:0] payload_bytes_out,
  output logic wake_up_frame_match_out,
  output logic remote_select_warn_out
);

  typedef struct packed {
    logic [5:0] sample_point_fraction;
    logic [28:0] ident;
    logic ide;
    logic rtr;
    logic [28:0] compare_enable;
    logic [3:0] length_code;
    logic config_valid_flag;
    logic [7:0] rdata;
    logic match;
  } swcf_state_t;

  swcf_state_t cur;
  swcf_state_t nxt;
  swcf_state_t rst_val;

  logic [7:0] rd_mux;
  logic rd_hit;
  logic changed;
  logic id_equal;

  // reset image; restart is deliberately not part of this
  always_comb begin
    rst_val = '0;
    rst_val.sample_point_fraction = RST_SAMPLE_POINT;
    rst_val.length_code = RST_LENGTH_CODE;
  end

  // read mux: reserved positions are tied to zero here, never stored
  always_comb begin
    rd_hit = 1'b1;
    rd_mux = RST_ZERO_BYTE;
    unique case (cfg_addr_in)
      ADDR_WAKE_SAMPLE_POINT: begin
        rd_mux = {2'h0, cur.sample_point_fraction};
      end
      ADDR_WAKE_ID_BYTE3: begin
        rd_mux = cur.ident[28:21];
      end
      ADDR_WAKE_ID_BYTE2: begin
        rd_mux = cur.ident[20:13];
      end
      ADDR_WAKE_ID_BYTE1: begin
        rd_mux = cur.ident[12:5];
      end
      ADDR_WAKE_ID_BYTE0_FORMAT: begin
        rd_mux = {1'b0, cur.ident[4:0], cur.rtr, cur.ide};
      end
      ADDR_WAKE_MASK_BYTE3: begin
        rd_mux = cur.compare_enable[28:21];
      end
      ADDR_WAKE_MASK_BYTE2: begin
        rd_mux = cur.compare_enable[20:13];
      end
      ADDR_WAKE_MASK_BYTE1: begin
        rd_mux = cur.compare_enable[12:5];
      end
      ADDR_WAKE_MASK_BYTE0: begin
        rd_mux = {1'b0, cur.compare_enable[4:0], 2'h0};
      end
      ADDR_WAKE_LENGTH_CODE: begin
        rd_mux = {4'h0, cur.length_code};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  assign id_equal = ((cur.ident ^ wake_up_frame_id_in) & cur.compare_enable) == 29'h0;

  always_comb begin
    nxt = cur;
    nxt.rdata = cfg_rd_in ? rd_mux : cur.rdata;
    if (cfg_wr_in) begin
      unique case (cfg_addr_in)
        ADDR_WAKE_SAMPLE_POINT: begin
          nxt.sample_point_fraction = cfg_wdata_in[5:0];
        end
        ADDR_WAKE_ID_BYTE3: begin
          nxt.ident[28:21] = cfg_wdata_in;
        end
        ADDR_WAKE_ID_BYTE2: begin
          nxt.ident[20:13] = cfg_wdata_in;
        end
        ADDR_WAKE_ID_BYTE1: begin
          nxt.ident[12:5] = cfg_wdata_in;
        end
        ADDR_WAKE_ID_BYTE0_FORMAT: begin
          nxt.ident[4:0] = cfg_wdata_in[6:2];
          nxt.rtr = cfg_wdata_in[POS_RTR];
          nxt.ide = cfg_wdata_in[POS_IDE];
        end
        ADDR_WAKE_MASK_BYTE3: begin
          nxt.compare_enable[28:21] = cfg_wdata_in;
        end
        ADDR_WAKE_MASK_BYTE2: begin
          nxt.compare_enable[20:13] = cfg_wdata_in;
        end
        ADDR_WAKE_MASK_BYTE1: begin
          nxt.compare_enable[12:5] = cfg_wdata_in;
        end
        ADDR_WAKE_MASK_BYTE0: begin
          nxt.compare_enable[4:0] = cfg_wdata_in[6:2];
        end
        ADDR_WAKE_LENGTH_CODE: begin
          nxt.length_code = cfg_wdata_in[3:0];
        end
        default: begin
        end
      endcase
    end
    // apart from the clear input and soft reset, only a real change of stored data drops the valid flag
    changed = ({nxt.sample_point_fraction, nxt.ident, nxt.rtr, nxt.ide, nxt.compare_enable, nxt.length_code}
               != {cur.sample_point_fraction, cur.ident, cur.rtr, cur.ide, cur.compare_enable, cur.length_code});
    if (config_valid_set_in) begin
      nxt.config_valid_flag = 1'b1;
    end
    if (config_valid_clear_in || changed) begin
      nxt.config_valid_flag = 1'b0;
    end
    // length code is matched bit by bit, not by byte count
    nxt.match = wake_up_frame_strobe_in && cur.config_valid_flag && id_equal
                && (wake_up_frame_ide_in == cur.ide) && (wake_up_frame_rtr_in == cur.rtr)
                && (wake_up_frame_dlc_in == cur.length_code);
    // restart leaves nxt untouched; soft reset reloads defaults
    if (soft_reset_in) begin
      nxt = rst_val;
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cur <= '0;
      cur.sample_point_fraction <= RST_SAMPLE_POINT;
      cur.length_code <= RST_LENGTH_CODE;
    end else begin
      cur <= nxt;
    end
  end

  assign cfg_rdata_out = cur.rdata;
  assign cfg_hit_out = rd_hit;
  assign config_valid_flag_out = cur.config_valid_flag;
  assign sample_point_fraction_out = cur.sample_point_fraction;
  assign ref_ident_out = cur.ident;
  assign compare_enable_out = cur.compare_enable;
  assign ref_rtr_out = cur.rtr;
  assign ref_ide_out = cur.ide;
  assign ref_length_code_out = cur.length_code;
  // codes above eight still carry eight bytes
  assign payload_bytes_out = (cur.length_code > LEN_MAX_BYTES) ? LEN_MAX_BYTES : cur.length_code;
  assign wake_up_frame_match_out = cur.match;
  // remote selection is legal to store but flagged for the system
  assign remote_select_warn_out = cur.rtr;

  logic unused_restart;
  assign unused_restart = restart_in;

endmodule

`default_nettype wire

// [swcf_can_node.sv]
// far-side node that presents received wake-up frames for one cycle
`timescale 1ns/1ps
`default_nettype none
module swcf_can_node (
  input wire logic clk_in,
  input wire logic send_in,
  input wire logic [28:0] id_in,
  input wire logic ide_in,
  input wire logic rtr_in,
  input wire logic [3:0] dlc_in,
  output var logic strobe_out = 1'b0,
  output var logic [28:0] id_out = 29'h0,
  output var logic ide_out = 1'b0,
  output var logic rtr_out = 1'b0,
  output var logic [3:0] dlc_out = 4'h0
);
  // fields go stale outside the strobe, so they are inverted rather than held
  always @(posedge clk_in) begin
    strobe_out <= send_in;
    if (send_in) begin
      {id_out, ide_out, rtr_out, dlc_out} <= {id_in, ide_in, rtr_in, dlc_in};
    end else begin
      {id_out, ide_out, rtr_out, dlc_out} <= ~{id_out, ide_out, rtr_out, dlc_out};
    end
  end
endmodule
`default_nettype wire

// [swcf_filter_config_sva.sv]
// port assertions for the wake filter configuration block
`timescale 1ns/1ps
`default_nettype none
module swcf_filter_config_sva (
  // clock, resets and strobes
  input wire logic clk_sys_in, arst_n_in, soft_reset_in, restart_in, cfg_wr_in, cfg_rd_in, cfg_hit_out,
  input wire logic [6:0] cfg_addr_in,
  input wire logic [7:0] cfg_wdata_in, cfg_rdata_out,
  // flags and decoded fields
  input wire logic config_valid_clear_in, config_valid_flag_out, wake_up_frame_strobe_in, wake_up_frame_match_out,
  input wire logic ref_rtr_out, remote_select_warn_out,
  input wire logic [5:0] sample_point_fraction_out,
  input wire logic [28:0] ref_ident_out,
  input wire logic [3:0] ref_length_code_out, payload_bytes_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  sp_reserved_a: assert property (cfg_rd_in && cfg_addr_in == 7'h22 |=> cfg_rdata_out[7:6] == 2'h0)
    else $error("sample point reserved bits read set");
  unmapped_zero_a: assert property (cfg_rd_in && !cfg_hit_out |=> cfg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  soft_defaults_a: assert property (soft_reset_in |=> sample_point_fraction_out == 6'h33 && ref_ident_out == 29'h0 && ref_length_code_out == 4'h0)
    else $error("soft reset defaults wrong");
  restart_keeps_a: assert property (restart_in && !cfg_wr_in && !soft_reset_in |=> $stable(ref_ident_out))
    else $error("restart changed identifier");
  id_high_byte_a: assert property (cfg_wr_in && cfg_addr_in == 7'h23 && !soft_reset_in |=> ref_ident_out[28:21] == $past(cfg_wdata_in))
    else $error("identifier high byte not stored");
  remote_warn_a: assert property (remote_select_warn_out == ref_rtr_out)
    else $error("remote warning differs from stored bit");
  len_clamp_a: assert property (payload_bytes_out == (ref_length_code_out > 4'h8 ? 4'h8 : ref_length_code_out))
    else $error("payload byte count wrong");
  valid_clear_a: assert property (config_valid_clear_in |=> !config_valid_flag_out)
    else $error("valid flag survived clear");
  match_cause_a: assert property (wake_up_frame_match_out |-> $past(wake_up_frame_strobe_in) && $past(config_valid_flag_out))
    else $error("match without valid strobe");
endmodule
bind swcf_filter_config swcf_filter_config_sva chk_i (.*);
`default_nettype wire

// [testbench.sv]
// self-checking bench for the wake filter configuration block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys_in = 1'b0, arst_n_in = 1'b0, soft_reset_in = 1'b0, restart_in = 1'b0, cfg_wr_in = 1'b0;
  logic cfg_rd_in = 1'b0, config_valid_set_in = 1'b0, config_valid_clear_in = 1'b0, send = 1'b0;
  logic [6:0] cfg_addr_in = 7'h0;
  logic [7:0] cfg_wdata_in = 8'h0, cfg_rdata_out;
  logic [28:0] f_id = 29'h0, wake_up_frame_id_in, ref_ident_out, compare_enable_out;
  logic [3:0] f_dlc = 4'h0, wake_up_frame_dlc_in, ref_length_code_out, payload_bytes_out;
  logic [5:0] sample_point_fraction_out;
  logic wake_up_frame_strobe_in, wake_up_frame_ide_in, wake_up_frame_rtr_in, cfg_hit_out, config_valid_flag_out;
  logic ref_rtr_out, ref_ide_out, wake_up_frame_match_out, remote_select_warn_out;
  int err_count = 0, num_checks = 0;
  // address, write data, read-back value; last row is unmapped
  // remote request bit stays zero in every write, wake frames are never remote frames
  logic [23:0] rows [11] = '{24'h22ff3f, 24'h23a5a5, 24'h245a5a, 24'h25c3c3, 24'h26fd7d, 24'h27ffff,
                            24'h280f0f, 24'h29f0f0, 24'h2aff7c, 24'h2bff0f, 24'h2c1200};
  localparam logic [28:0] EXP_REF = {8'ha5, 8'h5a, 8'hc3, 5'h1f};
  localparam logic [28:0] EXP_EN = {8'hff, 8'h0f, 8'hf0, 5'h1f};
  swcf_filter_config DUT (.*);
  swcf_can_node node (.clk_in(clk_sys_in), .send_in(send), .id_in(f_id), .ide_in(1'b1), .rtr_in(1'b0),
    .dlc_in(f_dlc), .strobe_out(wake_up_frame_strobe_in), .id_out(wake_up_frame_id_in),
    .ide_out(wake_up_frame_ide_in), .rtr_out(wake_up_frame_rtr_in), .dlc_out(wake_up_frame_dlc_in));
  initial forever #2.5 clk_sys_in = ~clk_sys_in;
  task automatic wrap_up;
    if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    cfg_wr_in <= 1'b1;
    cfg_addr_in <= a;
    cfg_wdata_in <= d;
    @(posedge clk_sys_in);
    cfg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    @(posedge clk_sys_in);
    cfg_rd_in <= 1'b1;
    cfg_addr_in <= a;
    @(posedge clk_sys_in);
    cfg_rd_in <= 1'b0;
    #1 v = cfg_rdata_out;
  endtask
  task automatic frame(input logic [28:0] id, input logic [3:0] dlc, input logic exp);
    @(posedge clk_sys_in);
    send <= 1'b1;
    f_id <= id;
    f_dlc <= dlc;
    @(posedge clk_sys_in);
    send <= 1'b0;
    @(posedge clk_sys_in);
    #1 chk(wake_up_frame_match_out, exp);
  endtask
  initial begin
    logic [7:0] v;
    repeat (10) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    foreach (rows[i]) begin
      rd(rows[i][22:16], v);
      chk(v, rows[i][23:16] == 8'h22 ? 8'h33 : 8'h00);
      wr(rows[i][22:16], rows[i][15:8]);
      rd(rows[i][22:16], v);
      chk(v, rows[i][7:0]);
    end
    chk(ref_ident_out, EXP_REF);
    chk(compare_enable_out, EXP_EN);
    chk({ref_rtr_out, ref_ide_out, remote_select_warn_out, payload_bytes_out}, 7'h28);
    chk(cfg_hit_out, 1'b0);
    @(posedge clk_sys_in) restart_in <= 1'b1;
    @(posedge clk_sys_in) restart_in <= 1'b0;
    rd(7'h26, v);
    chk(v, 8'h7d);
    wr(7'h26, 8'h7d);
    @(posedge clk_sys_in) config_valid_set_in <= 1'b1;
    @(posedge clk_sys_in) config_valid_set_in <= 1'b0;
    frame(EXP_REF ^ ~EXP_EN, 4'hf, 1'b1);
    frame(EXP_REF ^ 29'h1, 4'hf, 1'b0);
    frame(EXP_REF, 4'h9, 1'b0);
    wr(7'h2b, 8'h03);
    #1 chk(config_valid_flag_out, 1'b0);
    @(posedge clk_sys_in) config_valid_clear_in <= 1'b1;
    @(posedge clk_sys_in) config_valid_clear_in <= 1'b0;
    @(posedge clk_sys_in) soft_reset_in <= 1'b1;
    @(posedge clk_sys_in) soft_reset_in <= 1'b0;
    rd(7'h22, v);
    chk(v, 8'h33);
    wrap_up;
  end
  initial begin
    repeat (2000) @(posedge clk_sys_in);
    err_count++;
    wrap_up;
  end
endmodule
`default_nettype wire
